/* File: verilog/can_rrc_pkg.sv */
// ----------------------------------------
// shared constants and types
// ----------------------------------------
package can_rrc_pkg;
  localparam int RETRY_W = 4;
  localparam int REINT_W = 8;
  localparam int FFC_W = 4;
  localparam logic [RETRY_W-1:0] RETRY_ZERO = 4'h0;
  localparam logic [RETRY_W-1:0] RETRY_STEP = 4'h1;
  localparam logic [REINT_W-1:0] REINT_ZERO = 8'h00;
  localparam logic [REINT_W-1:0] REINT_STEP = 8'h01;
  localparam logic [REINT_W-1:0] REINT_LAST = 8'h80;
  localparam logic [FFC_W-1:0] FFC_PRELOAD = 4'hA;
  localparam logic [FFC_W-1:0] FFC_ZERO = 4'h0;
  localparam logic [FFC_W-1:0] FFC_STEP = 4'h1;

  typedef enum logic [0:0] {REINT_IDLE, REINT_RUN} reint_state_e;
endpackage : can_rrc_pkg

/* File: verilog/ffc_if.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// control of the frame-field counter
// ----------------------------------------
interface ffc_if;
  import can_rrc_pkg::*;
  logic preload;
  logic decrement;
  logic zero;
  logic [FFC_W-1:0] value;
  modport ctl (output preload, output decrement, input zero, input value);
  modport ctr (input preload, input decrement, output zero, output value);
endinterface : ffc_if
`default_nettype wire

/* File: verilog/frame_field_counter.sv */
`timescale 1ns/100ps
`default_nettype none
module frame_field_counter
  import can_rrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  ffc_if.ctr ffc
);
  typedef struct packed {
    logic [FFC_W-1:0] value;
  } ffc_state_s;

  ffc_state_s s_r;
  ffc_state_s s_nxt;

  // preload wins over decrement; decrement saturates at zero
  always_comb
  begin
    s_nxt = s_r;
    if (ffc.preload)
      s_nxt.value = FFC_PRELOAD;
    else if (ffc.decrement && s_r.value != FFC_ZERO)
      s_nxt.value = s_r.value - FFC_STEP;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ffc.value = s_r.value;
  assign ffc.zero = (s_r.value == FFC_ZERO);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_ffc_preload;
    @(posedge clock) disable iff (!rst_b)
    ffc.preload |=> ffc.value == FFC_PRELOAD;
  endproperty
  a_ffc_preload: assert property (p_ffc_preload)
    else $error("frame-field counter not preloaded");

  property p_ffc_dec;
    @(posedge clock) disable iff (!rst_b)
    ffc.decrement && !ffc.preload && !ffc.zero
      |=> ffc.value == $past(ffc.value) - FFC_STEP;
  endproperty
  a_ffc_dec: assert property (p_ffc_dec)
    else $error("frame-field counter did not decrement");
endmodule : frame_field_counter
`default_nettype wire

/* File: verilog/can_retransmit_reintegration_ctr.sv */
`timescale 1ns/100ps
`default_nettype none
module can_retransmit_reintegration_ctr
  import can_rrc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic retry_limit_enable,
  input wire logic [RETRY_W-1:0] retry_limit_threshold,
  input wire logic error_counter_reset_cmd,
  input wire logic bus_off,
  input wire logic process_stage,
  input wire logic rx_recessive,
  input wire logic frame_start,
  input wire logic tx_attempt,
  input wire logic arb_lost,
  input wire logic err_frame_req,
  input wire logic buf_changed,
  input wire logic buf_tx_ok,
  input wire logic buf_tx_failed,
  input wire logic buf_aborted,
  output logic [RETRY_W-1:0] retry_count,
  output logic retry_limit_hit,
  output logic tx_fail_cmd,
  output logic [REINT_W-1:0] reint_count,
  output logic reint_active,
  output logic reint_done
);
  typedef struct packed {
    reint_state_e reint_st;
    logic [RETRY_W-1:0] retry_cnt;
    logic counted;
    logic limit_hit;
    logic fail_cmd;
    logic [REINT_W-1:0] reint_cnt;
    logic reint_done;
  } ctr_state_s;

  ctr_state_s s_r;
  ctr_state_s s_nxt;

  ffc_if ffc ();

  frame_field_counter u_ffc (
    .clock(clock),
    .rst_b(rst_b),
    .ffc(ffc)
  );

  // ----------------------------------------
  // retry decode
  // ----------------------------------------
  function automatic logic at_limit(input logic [RETRY_W-1:0] cnt,
                                    input logic [RETRY_W-1:0] thr);
    // >= guards against the threshold being lowered mid-sequence
    at_limit = (cnt >= thr);
  endfunction : at_limit

  logic retry_clr;
  logic tx_evt;
  logic hit_now;
  logic reint_run;
  logic reint_req;
  logic run_bit;
  logic run_end;

  assign reint_run = (s_r.reint_st == REINT_RUN);
  // frames on the bus are not ours while rejoining
  assign tx_evt = (arb_lost | err_frame_req) & tx_attempt & ~s_r.counted
                  & ~reint_run;
  assign retry_clr = buf_changed | buf_tx_ok | buf_tx_failed
                     | buf_aborted;
  assign hit_now = retry_limit_enable
                   & at_limit(s_r.retry_cnt, retry_limit_threshold);

  // ----------------------------------------
  // reintegration decode
  // ----------------------------------------
  assign reint_req = ~reint_run & bus_off & error_counter_reset_cmd;
  assign run_bit = reint_run & process_stage;
  assign run_end = run_bit & rx_recessive & ffc.zero;

  assign ffc.preload = reint_req | run_end
                       | (run_bit & ~rx_recessive);
  assign ffc.decrement = run_bit & rx_recessive & ~ffc.zero;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fail_cmd = 1'b0;
    s_nxt.reint_done = 1'b0;

    // a new frame opens a fresh once-per-frame window; a hit in the same
    // cycle still marks the window as used
    if (frame_start)
      s_nxt.counted = 1'b0;
    if (tx_evt)
      s_nxt.counted = 1'b1;

    if (!retry_limit_enable)
      s_nxt.retry_cnt = RETRY_ZERO;
    else if (retry_clr)
      s_nxt.retry_cnt = RETRY_ZERO;
    else if (tx_evt && hit_now)
    begin
      // give up: buffer is told to fail, which also clears the count
      s_nxt.fail_cmd = 1'b1;
      s_nxt.retry_cnt = RETRY_ZERO;
    end
    else if (tx_evt)
      s_nxt.retry_cnt = s_r.retry_cnt + RETRY_STEP;

    s_nxt.limit_hit = retry_limit_enable
                      & at_limit(s_nxt.retry_cnt, retry_limit_threshold);

    case (s_r.reint_st)
      REINT_IDLE:
      begin
        if (reint_req)
        begin
          s_nxt.reint_st = REINT_RUN;
          s_nxt.reint_cnt = REINT_ZERO;
        end
      end
      REINT_RUN:
      begin
        if (run_end)
        begin
          if (s_r.reint_cnt == REINT_LAST)
          begin
            s_nxt.reint_st = REINT_IDLE;
            s_nxt.reint_done = 1'b1;
          end
          else
            s_nxt.reint_cnt = s_r.reint_cnt + REINT_STEP;
        end
      end
      default:
        s_nxt.reint_st = REINT_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.reint_st <= REINT_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign retry_count = s_r.retry_cnt;
  assign retry_limit_hit = s_r.limit_hit;
  assign tx_fail_cmd = s_r.fail_cmd;
  assign reint_count = s_r.reint_cnt;
  assign reint_active = reint_run;
  assign reint_done = s_r.reint_done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_retry_held;
    !retry_limit_enable |=> retry_count == RETRY_ZERO;
  endproperty
  a_retry_held: assert property (p_retry_held)
    else $error("retry count not held at zero while disabled");

  property p_no_fail_disabled;
    !retry_limit_enable |=> !tx_fail_cmd;
  endproperty
  a_no_fail_disabled: assert property (p_no_fail_disabled)
    else $error("failed command while limiting disabled");

  property p_retry_inc;
    tx_evt && retry_limit_enable && !hit_now && !retry_clr
      |=> retry_count == $past(retry_count) + RETRY_STEP;
  endproperty
  a_retry_inc: assert property (p_retry_inc)
    else $error("retry count did not step by one");

  property p_once_per_frame;
    s_r.counted && !frame_start && retry_limit_enable && !retry_clr
      ##1 retry_limit_enable && !retry_clr |-> $stable(retry_count);
  endproperty
  a_once_per_frame: assert property (p_once_per_frame)
    else $error("retry counted twice in one frame");

  property p_fail_on_limit;
    tx_evt && hit_now && !retry_clr |=> tx_fail_cmd && retry_count == RETRY_ZERO;
  endproperty
  a_fail_on_limit: assert property (p_fail_on_limit)
    else $error("limit reached but frame not abandoned");

  property p_one_shot;
    tx_evt && retry_limit_enable && retry_limit_threshold == RETRY_ZERO
      && !retry_clr |=> tx_fail_cmd;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot frame was retried");

  property p_rx_only;
    !tx_attempt && retry_limit_enable && !retry_clr |=> $stable(retry_count);
  endproperty
  a_rx_only: assert property (p_rx_only)
    else $error("retry count moved in a receive-only frame");

  property p_retry_clear;
    retry_clr && retry_limit_enable |=> retry_count == RETRY_ZERO;
  endproperty
  a_retry_clear: assert property (p_retry_clear)
    else $error("retry count not cleared on buffer change or end");

  property p_reint_start;
    reint_req |=> reint_active && reint_count == REINT_ZERO
      && ffc.value == FFC_PRELOAD;
  endproperty
  a_reint_start: assert property (p_reint_start)
    else $error("reintegration request not accepted");

  property p_reint_inc;
    run_end && reint_count != REINT_LAST
      |=> reint_count == $past(reint_count) + REINT_STEP;
  endproperty
  a_reint_inc: assert property (p_reint_inc)
    else $error("reintegration count did not step");

  property p_reint_dominant;
    run_bit && !rx_recessive |=> ffc.value == FFC_PRELOAD && $stable(reint_count);
  endproperty
  a_reint_dominant: assert property (p_reint_dominant)
    else $error("dominant bit did not restart the recessive run");

  property p_reint_done;
    run_end && reint_count == REINT_LAST |=> reint_done && !reint_active
      ##1 !reint_done;
  endproperty
  a_reint_done: assert property (p_reint_done)
    else $error("reintegration did not finish at 128");

  property p_ffc_still;
    !process_stage && !reint_req |=> $stable(ffc.value);
  endproperty
  a_ffc_still: assert property (p_ffc_still)
    else $error("frame-field counter moved outside process stage");

  property p_err_once;
    s_r.counted && err_frame_req |=> !tx_fail_cmd;
  endproperty
  a_err_once: assert property (p_err_once)
    else $error("repeated error frame in one frame abandoned it");

  property p_passive_rx;
    !tx_attempt |=> !tx_fail_cmd;
  endproperty
  a_passive_rx: assert property (p_passive_rx)
    else $error("frame abandoned while only receiving");

  property p_abort_clear;
    buf_aborted |=> retry_count == RETRY_ZERO && !tx_fail_cmd;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("retry count not cleared on abort");

  property p_rejoin_only_bus_off;
    !reint_active && !bus_off |=> !reint_active;
  endproperty
  a_rejoin_only_bus_off: assert property (p_rejoin_only_bus_off)
    else $error("reintegration started while not bus-off");

  property p_rejoin_ignores_frames;
    reint_active && retry_limit_enable && !retry_clr
      |=> $stable(retry_count) && !tx_fail_cmd;
  endproperty
  a_rejoin_ignores_frames: assert property (p_rejoin_ignores_frames)
    else $error("bus frame counted during reintegration");

  cover property (reint_req);
  cover property (tx_evt && hit_now);
  cover property (s_r.retry_cnt == retry_limit_threshold && retry_clr);
  cover property (run_end && reint_count == REINT_LAST);
  cover property (run_bit && !rx_recessive && !ffc.zero);
endmodule : can_retransmit_reintegration_ctr
`default_nettype wire

/* File: tb/bus_bit_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bit stream from the protocol side
// ----------------------------------------
module bus_bit_model
(
  input wire logic clock,
  output logic process_stage,
  output logic rx_recessive
);
  initial
  begin
    process_stage = 1'h0;
    rx_recessive = 1'h0;
  end

  // one bit per call; the value is only valid with the process pulse
  task automatic send_bit(input logic v);
    begin
      @(posedge clock);
      process_stage <= 1'h1;
      rx_recessive <= v;
      @(posedge clock);
      process_stage <= 1'h0;
      // invert so a stale bit is never mistaken for a fresh one
      rx_recessive <= ~v;
      #1;
    end
  endtask : send_bit
endmodule : bus_bit_model
`default_nettype wire

/* File: tb/can_retransmit_reintegration_ctr_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module can_retransmit_reintegration_ctr_tb;
  import can_rrc_pkg::*;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic retry_limit_enable = 1'h0;
  logic [RETRY_W-1:0] retry_limit_threshold = 4'h0;
  logic error_counter_reset_cmd = 1'h0, bus_off = 1'h0, frame_start = 1'h0;
  logic tx_attempt = 1'h1, arb_lost = 1'h0, err_frame_req = 1'h0;
  logic [3:0] buf_ev = 4'h0;
  logic process_stage, rx_recessive, retry_limit_hit, tx_fail_cmd, reint_active, reint_done;
  logic [RETRY_W-1:0] retry_count;
  logic [REINT_W-1:0] reint_count;
  int err_total = 0;
  int comparisons = 0;
  int thr;

  always #4 clock = ~clock;

  bus_bit_model bus_u (.clock(clock), .process_stage(process_stage),
    .rx_recessive(rx_recessive));

  can_retransmit_reintegration_ctr dut_u (.clock(clock), .rst_b(rst_b),
    .retry_limit_enable(retry_limit_enable), .retry_limit_threshold(retry_limit_threshold),
    .error_counter_reset_cmd(error_counter_reset_cmd), .bus_off(bus_off),
    .process_stage(process_stage), .rx_recessive(rx_recessive), .frame_start(frame_start),
    .tx_attempt(tx_attempt), .arb_lost(arb_lost), .err_frame_req(err_frame_req),
    .buf_changed(buf_ev[0]), .buf_tx_ok(buf_ev[1]), .buf_tx_failed(buf_ev[2]),
    .buf_aborted(buf_ev[3]), .retry_count(retry_count), .retry_limit_hit(retry_limit_hit),
    .tx_fail_cmd(tx_fail_cmd), .reint_count(reint_count), .reint_active(reint_active),
    .reint_done(reint_done));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // expected count after n failures: fail abandons the frame once n exceeds thr
  function automatic logic [RETRY_W-1:0] exp_cnt(input int n, input int t);
    return (n > t) ? RETRY_ZERO : RETRY_W'(n);
  endfunction : exp_cnt

  task automatic ev(input logic [1:0] ae);
    begin
      @(posedge clock);
      {arb_lost, err_frame_req} <= ae;
      @(posedge clock);
      {arb_lost, err_frame_req} <= 2'h0;
      #1;
    end
  endtask : ev

  task automatic nf();
    begin
      @(posedge clock);
      frame_start <= 1'h1;
      @(posedge clock);
      frame_start <= 1'h0;
      #1;
    end
  endtask : nf

  task automatic bufp(input int k);
    begin
      @(posedge clock);
      buf_ev[k] <= 1'h1;
      @(posedge clock);
      buf_ev[k] <= 1'h0;
      #1;
    end
  endtask : bufp

  task automatic cmd();
    begin
      @(posedge clock);
      error_counter_reset_cmd <= 1'h1;
      @(posedge clock);
      error_counter_reset_cmd <= 1'h0;
      #1;
    end
  endtask : cmd

  task automatic run11();
    begin
      repeat (11) bus_u.send_bit(1'h1);
    end
  endtask : run11

  // mid-run reset, asserted and released on clock edges
  task automatic reset_pulse();
    begin
      @(posedge clock);
      rst_b <= 1'h0;
      repeat (2) @(posedge clock);
      rst_b <= 1'h1;
      #1;
      `CHK(retry_count, RETRY_ZERO)
      `CHK(tx_fail_cmd, 1'h0)
      `CHK(reint_active, 1'h0)
    end
  endtask : reset_pulse

  // random soak against a reference of the retry rules, one draw per edge;
  // must start right after reset so both sides begin from a known state
  task automatic soak(input int n);
    logic en, fs, ta, cm, bo, evt, counted, fail, hit, ract;
    logic [1:0] ae;
    logic [3:0] be;
    logic [RETRY_W-1:0] cnt;
    begin
      en = retry_limit_enable;
      fs = 1'h0;
      ta = tx_attempt;
      cm = 1'h0;
      bo = bus_off;
      ae = 2'h0;
      be = 4'h0;
      cnt = RETRY_ZERO;
      counted = 1'h0;
      ract = 1'h0;
      repeat (n)
      begin
        @(posedge clock);
        // the draw made at the last edge is what the design took here
        evt = (ae != 2'h0) && ta && !counted && !ract;
        fail = en && (be == 4'h0) && evt && (cnt >= retry_limit_threshold);
        if (fs)
          counted = 1'h0;
        if (evt)
          counted = 1'h1;
        if (!en || be != 4'h0 || fail)
          cnt = RETRY_ZERO;
        else if (evt)
          cnt = cnt + RETRY_STEP;
        hit = en && (cnt >= retry_limit_threshold);
        if (cm && bo)
          ract = 1'h1;
        en = ($urandom_range(7, 0) != 0);
        fs = ($urandom_range(3, 0) == 0);
        ta = ($urandom_range(3, 0) != 0);
        ae = 2'($urandom_range(3, 0));
        be = ($urandom_range(15, 0) == 0) ? 4'(1 << $urandom_range(3, 0)) : 4'h0;
        cm = ($urandom_range(31, 0) == 0);
        bo = ($urandom_range(7, 0) == 0);
        retry_limit_enable <= en;
        frame_start <= fs;
        tx_attempt <= ta;
        {arb_lost, err_frame_req} <= ae;
        buf_ev <= be;
        error_counter_reset_cmd <= cm;
        bus_off <= bo;
        #1;
        `CHK(retry_count, cnt)
        `CHK(tx_fail_cmd, fail)
        `CHK(retry_limit_hit, hit)
        `CHK(reint_active, ract)
      end
      @(posedge clock);
      retry_limit_enable <= 1'h1;
      frame_start <= 1'h0;
      tx_attempt <= 1'h1;
      {arb_lost, err_frame_req} <= 2'h0;
      buf_ev <= 4'h0;
      error_counter_reset_cmd <= 1'h0;
      bus_off <= 1'h0;
    end
  endtask : soak

  task automatic wrap_up();
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask : wrap_up

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #200us;
    err_total++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h2153));
    repeat (16) @(posedge clock);
    rst_b <= 1'h1;
    repeat (20)
    begin
      nf();
      ev(2'h3);
      `CHK(retry_count, RETRY_ZERO)
      `CHK(tx_fail_cmd, 1'h0)
    end
    $display("test disabled done");
    @(posedge clock);
    retry_limit_enable <= 1'h1;
    retry_limit_threshold <= 4'h2;
    nf();
    ev(2'h3);
    `CHK(retry_count, 4'h1)
    ev(2'h1);
    `CHK(retry_count, 4'h1)
    nf();
    ev(2'h2);
    ev(2'h1);
    `CHK(retry_count, 4'h2)
    `CHK(retry_limit_hit, 1'h1)
    `CHK(tx_fail_cmd, 1'h0)
    nf();
    ev(2'h1);
    `CHK(tx_fail_cmd, 1'h1)
    `CHK(retry_count, RETRY_ZERO)
    $display("test limit done");
    for (int k = 0; k < 4; k++)
    begin
      nf();
      ev(2'h2);
      bufp(k);
      `CHK(retry_count, RETRY_ZERO)
    end
    nf();
    ev(2'h2);
    @(posedge clock);
    tx_attempt <= 1'h0;
    nf();
    ev(2'h3);
    `CHK(retry_count, 4'h1)
    @(posedge clock);
    tx_attempt <= 1'h1;
    bufp(3);
    $display("test clears done");
    @(posedge clock);
    retry_limit_threshold <= 4'h0;
    nf();
    `CHK(retry_limit_hit, 1'h1)
    ev(2'h2);
    `CHK(tx_fail_cmd, 1'h1)
    repeat (6)
    begin
      thr = $urandom_range(15, 1);
      @(posedge clock);
      retry_limit_threshold <= RETRY_W'(thr);
      for (int i = 1; i <= thr + 1; i++)
      begin
        nf();
        ev(2'($urandom_range(3, 1)));
        `CHK(retry_count, exp_cnt(i, thr))
        `CHK(tx_fail_cmd, (i > thr))
      end
    end
    $display("test random limit done");
    reset_pulse();
    soak(400);
    reset_pulse();
    $display("test random soak done");
    cmd();
    `CHK(reint_active, 1'h0)
    @(posedge clock);
    bus_off <= 1'h1;
    cmd();
    `CHK(reint_active, 1'h1)
    `CHK(reint_count, REINT_ZERO)
    repeat (7) bus_u.send_bit(1'h1);
    bus_u.send_bit(1'h0);
    repeat (10) bus_u.send_bit(1'h1);
    `CHK(reint_count, REINT_ZERO)
    bus_u.send_bit(1'h1);
    `CHK(reint_count, REINT_STEP)
    for (int r = 2; r <= 128; r++)
    begin
      repeat ($urandom_range(3, 0)) bus_u.send_bit(1'($urandom_range(1, 0)));
      bus_u.send_bit(1'h0);
      run11();
      `CHK(reint_count, REINT_W'(r))
    end
    `CHK(reint_done, 1'h0)
    run11();
    `CHK(reint_done, 1'h1)
    `CHK(reint_active, 1'h0)
    `CHK(reint_count, REINT_LAST)
    @(posedge clock);
    bus_off <= 1'h0;
    $display("test reintegration done");
    wrap_up();
  end
endmodule : can_retransmit_reintegration_ctr_tb
`default_nettype wire
